// *** logic/slope_pkg.sv ***
/*
 Constants, register map and types of the frequency slope stage.
 Assumes a 20 MHz core clock and a 32-bit APB register bus.
*/
package slope_pkg;

   // -----------------------------------------------------------------
   // Clock and timing
   // -----------------------------------------------------------------
   localparam int CLK_NS         = 50;
   localparam int TICK_MS        = 10;
   localparam int TICK_CYCLES    = (TICK_MS * 1000000) / CLK_NS;
   localparam int PICKUP_MS      = 80;
   localparam int START_DLY_MS   = 60;
   localparam int STABLE_MS      = 80;
   localparam int STEP_MS        = 20;
   localparam int LOW_SLOPE_MS   = 300;
   localparam int PICKUP_TICKS   = (PICKUP_MS + TICK_MS - 1) / TICK_MS;
   localparam int START_TICKS    = (START_DLY_MS + TICK_MS - 1) / TICK_MS;
   localparam int STABLE_TICKS   = (STABLE_MS + TICK_MS - 1) / TICK_MS;
   localparam int STEP_TICKS     = STEP_MS / TICK_MS;
   localparam int LOW_MIN_TICKS  = (LOW_SLOPE_MS + TICK_MS - 1) / TICK_MS;

   // -----------------------------------------------------------------
   // Widths
   // -----------------------------------------------------------------
   localparam int THR_W  = 7;
   localparam int TIM_W  = 9;
   localparam int CNT_W  = 12;
   localparam int SUM_W  = 26;
   localparam int FRQ_W  = 16;

   // -----------------------------------------------------------------
   // Setting limits, units 0.1 Hz/s and 20 ms
   // -----------------------------------------------------------------
   localparam logic [TIM_W-1:0] THR_MIN  = 9'h002;
   localparam logic [TIM_W-1:0] THR_MAX  = 9'h064;
   localparam logic [TIM_W-1:0] TIM_MIN  = 9'h007;
   localparam logic [TIM_W-1:0] TIM_MAX  = 9'h1F4;
   localparam logic [THR_W-1:0] THR_RST  = 7'h05;
   localparam logic [TIM_W-1:0] TIM_RST  = 9'h01E;
   localparam logic [THR_W-1:0] LOW_THR  = 7'h07;

   // -----------------------------------------------------------------
   // Register map, byte addresses
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
   localparam logic [7:0] OFS_SUM      = 8'h10;
   localparam logic [7:0] OFS_ELAPSED  = 8'h14;
   localparam logic [1:0] GRP_REGION   = 2'h1;
   localparam logic [1:0] FLD_THR      = 2'h0;
   localparam logic [1:0] FLD_T        = 2'h1;
   localparam logic [1:0] FLD_MINIMUM_TRIP_DELAY     = 2'h2;
   localparam int         CTRL_EN_BIT  = 0;
   localparam int         CTRL_GRP_LSB = 1;
   localparam int         IRQ_START    = 0;
   localparam int         IRQ_TRIP     = 1;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_PICKUP = 2'b01,
      ST_RUN    = 2'b10
   } st_t;

endpackage

// *** logic/slope_tick.sv ***
/*
 Processing tick generator: one-cycle pulse every CYCLES clocks.
 Assumes a synchronised active-low reset.
*/
`timescale 1ns/1ns
module slope_tick #(
   parameter int CYCLES = slope_pkg::TICK_CYCLES
) (
   input  wire logic clk_in,
   input  wire logic rstn_in,
   output logic      tick_out
);

   typedef struct packed {
      logic [31:0] cnt;
      logic        tick;
   } tick_t;

   tick_t r;
   tick_t n;

   always_comb begin
      n = r;
      n.tick = 1'b0;
      if (r.cnt >= 32'(CYCLES - 1)) begin
         n.cnt  = 32'h00000000;
         n.tick = 1'b1;
      end else begin
         n.cnt = r.cnt + 32'h00000001;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign tick_out = r.tick;

endmodule

// *** logic/slope_settings.sv ***
/*
 Four groups of stage settings with one write port and two registered
 read ports. Assumes written values are already range limited.
*/
`timescale 1ns/1ns
module slope_settings (
   input  wire logic                         clk_in,
   input  wire logic                         rstn_in,
   input  wire logic                         we_in,
   input  wire logic [1:0]                   wgrp_in,
   input  wire logic [1:0]                   wfld_in,
   input  wire logic [slope_pkg::TIM_W-1:0]  wdata_in,
   input  wire logic [1:0]                   agrp_in,
   output logic      [slope_pkg::THR_W-1:0]  athr_out,
   output logic      [slope_pkg::TIM_W-1:0]  at_out,
   output logic      [slope_pkg::TIM_W-1:0]  atmin_out,
   input  wire logic [1:0]                   bgrp_in,
   output logic      [slope_pkg::THR_W-1:0]  bthr_out,
   output logic      [slope_pkg::TIM_W-1:0]  bt_out,
   output logic      [slope_pkg::TIM_W-1:0]  btmin_out
);

   typedef struct packed {
      logic [3:0][slope_pkg::THR_W-1:0] thr;
      logic [3:0][slope_pkg::TIM_W-1:0] t;
      logic [3:0][slope_pkg::TIM_W-1:0] minimum_trip_delay;
      logic [slope_pkg::THR_W-1:0]      athr;
      logic [slope_pkg::TIM_W-1:0]      at;
      logic [slope_pkg::TIM_W-1:0]      atmin;
      logic [slope_pkg::THR_W-1:0]      bthr;
      logic [slope_pkg::TIM_W-1:0]      bt;
      logic [slope_pkg::TIM_W-1:0]      btmin;
   } mem_t;

   mem_t r;
   mem_t n;

   always_comb begin
      n = r;
      if (we_in) begin
         unique case (wfld_in)
            slope_pkg::FLD_THR:  n.thr[wgrp_in]  = wdata_in[slope_pkg::THR_W-1:0];
            slope_pkg::FLD_T:    n.t[wgrp_in]    = wdata_in;
            slope_pkg::FLD_MINIMUM_TRIP_DELAY: n.minimum_trip_delay[wgrp_in] = wdata_in;
            default:             n.t[wgrp_in]    = r.t[wgrp_in];
         endcase
      end
      n.athr  = r.thr[agrp_in];
      n.at    = r.t[agrp_in];
      n.atmin = r.minimum_trip_delay[agrp_in];
      n.bthr  = r.thr[bgrp_in];
      n.bt    = r.t[bgrp_in];
      n.btmin = r.minimum_trip_delay[bgrp_in];
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         r       <= '0;
         r.thr   <= {4{slope_pkg::THR_RST}};
         r.t     <= {4{slope_pkg::TIM_RST}};
         r.minimum_trip_delay  <= {4{slope_pkg::TIM_RST}};
         r.athr  <= slope_pkg::THR_RST;
         r.at    <= slope_pkg::TIM_RST;
         r.atmin <= slope_pkg::TIM_RST;
         r.bthr  <= slope_pkg::THR_RST;
         r.bt    <= slope_pkg::TIM_RST;
         r.btmin <= slope_pkg::TIM_RST;
      end else begin
         r <= n;
      end
   end

   assign athr_out  = r.athr;
   assign at_out    = r.at;
   assign atmin_out = r.atmin;
   assign bthr_out  = r.bthr;
   assign bt_out    = r.bt;
   assign btmin_out = r.btmin;

endmodule

// *** logic/slope_stage.sv ***
/*
 Rate-of-change-of-frequency protection stage with APB registers.
 Assumes FREQ_IN (mHz) comes from logic on the core clock and that
 LV_BLOCK_IN is an asynchronous level from outside.
*/
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ns
// Operation
// - Start after slope above threshold 80 ms
// - Start output 60 ms after start
// - Trip only if average still exceeds threshold
// - Equal delays give definite time trip
// - Reset after 80 ms stable, tripped or delay expired
// - Keep averaging over fluctuations since start
// - Dependent time threshold times delay over slope
// - Never trip before minimum delay
// - Threshold range 0.2 to 10 Hz/s
// - Delays range 0.14 to 10 s
// - Four setting groups, one active
// - Larger floor for thresholds below 0.7
// - Low-voltage blocking holds stage idle
module slope_stage #(
   parameter int TICK_CYCLES = slope_pkg::TICK_CYCLES
) (
   input  wire logic                        CORE_CLK_IN,
   input  wire logic                        RSTN_IN,
   input  wire logic                        PSEL_IN,
   input  wire logic                        PENABLE_IN,
   input  wire logic                        PWRITE_IN,
   input  wire logic [7:0]                  PADDR_IN,
   input  wire logic [31:0]                 PWDATA_IN,
   output logic      [31:0]                 PRDATA_OUT,
   output logic                             PREADY_OUT,
   output logic                             PSLVERR_OUT,
   input  wire logic [slope_pkg::FRQ_W-1:0] FREQ_IN,
   input  wire logic                        LV_BLOCK_IN,
   output logic                             START_OUT,
   output logic                             TRIP_OUT,
   output logic                             IRQ_OUT
);

   // ----------------------------------------------------------------
   // Types and functions
   // ----------------------------------------------------------------
   typedef struct packed {
      slope_pkg::st_t                st;
      logic [slope_pkg::CNT_W-1:0]   pick;
      logic [slope_pkg::CNT_W-1:0]   el;
      logic [slope_pkg::CNT_W-1:0]   stab;
      logic [slope_pkg::SUM_W-1:0]   sum;
      logic [slope_pkg::FRQ_W-1:0]   prev;
      logic                          have_prev;
      logic                          start;
      logic                          trip;
      logic                          en;
      logic [1:0]                    grp;
      logic [1:0]                    irq_st;
      logic [1:0]                    irq_mask;
      logic [31:0]                   prdata;
      logic                          pready;
      logic                          pslverr;
      logic                          irq;
      logic                          lv1;
      logic                          lv2;
   } regs_t;

   function automatic logic [slope_pkg::SUM_W-1:0] mul_thr(
      input logic [slope_pkg::CNT_W-1:0] a,
      input logic [slope_pkg::THR_W-1:0] thr);
      mul_thr = slope_pkg::SUM_W'(a) * slope_pkg::SUM_W'(thr);
   endfunction

   function automatic logic [slope_pkg::CNT_W-1:0] to_ticks(
      input logic [slope_pkg::TIM_W-1:0] v);
      to_ticks = slope_pkg::CNT_W'(v) * slope_pkg::CNT_W'(slope_pkg::STEP_TICKS);
   endfunction

   function automatic logic [slope_pkg::TIM_W-1:0] clamp(
      input logic [31:0]                 v,
      input logic [slope_pkg::TIM_W-1:0] lo,
      input logic [slope_pkg::TIM_W-1:0] hi);
      if (v < 32'(lo)) begin
         clamp = lo;
      end else if (v > 32'(hi)) begin
         clamp = hi;
      end else begin
         clamp = v[slope_pkg::TIM_W-1:0];
      end
   endfunction

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_s1;
   logic rstn;

   always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         rst_s1 <= 1'b0;
         rstn   <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rstn   <= rst_s1;
      end
   end

   // ----------------------------------------------------------------
   // Tick and settings
   // ----------------------------------------------------------------
   regs_t                         r;
   regs_t                         n;
   logic                          tick;
   logic                          mem_we;
   logic [slope_pkg::TIM_W-1:0]   mem_wdata;
   logic [slope_pkg::THR_W-1:0]   thr;
   logic [slope_pkg::TIM_W-1:0]   t_set;
   logic [slope_pkg::TIM_W-1:0]   minimum_trip_delay_set;
   logic [slope_pkg::THR_W-1:0]   b_thr;
   logic [slope_pkg::TIM_W-1:0]   b_t;
   logic [slope_pkg::TIM_W-1:0]   b_minimum_trip_delay;

   slope_tick #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .clk_in   (CORE_CLK_IN),
      .rstn_in  (rstn),
      .tick_out (tick)
   );

   slope_settings u_settings (
      .clk_in    (CORE_CLK_IN),
      .rstn_in   (rstn),
      .we_in     (mem_we),
      .wgrp_in   (PADDR_IN[5:4]),
      .wfld_in   (PADDR_IN[3:2]),
      .wdata_in  (mem_wdata),
      .agrp_in   (r.grp),
      .athr_out  (thr),
      .at_out    (t_set),
      .atmin_out (minimum_trip_delay_set),
      .bgrp_in   (PADDR_IN[5:4]),
      .bthr_out  (b_thr),
      .bt_out    (b_t),
      .btmin_out (b_minimum_trip_delay)
   );

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic        acc_first;
   logic        acc_done;
   logic        grp_hit;
   logic        mapped;
   logic        wr_done;
   logic [31:0] rd_word;

   always_comb begin
      acc_first = PSEL_IN & PENABLE_IN & ~r.pready;
      acc_done  = PSEL_IN & PENABLE_IN & r.pready;
      grp_hit   = (PADDR_IN[7:6] == slope_pkg::GRP_REGION) &&
                  (PADDR_IN[3:2] != 2'h3) && (PADDR_IN[1:0] == 2'h0);
      mapped    = grp_hit || (PADDR_IN == slope_pkg::OFS_CTRL) ||
                  (PADDR_IN == slope_pkg::OFS_STATUS) ||
                  (PADDR_IN == slope_pkg::OFS_IRQ_STAT) ||
                  (PADDR_IN == slope_pkg::OFS_IRQ_MASK) ||
                  (PADDR_IN == slope_pkg::OFS_SUM) ||
                  (PADDR_IN == slope_pkg::OFS_ELAPSED);
      wr_done   = acc_done & PWRITE_IN & mapped;
      mem_we    = wr_done & grp_hit;
      if (PADDR_IN[3:2] == slope_pkg::FLD_THR) begin
         mem_wdata = clamp(PWDATA_IN, slope_pkg::THR_MIN, slope_pkg::THR_MAX);
      end else begin
         mem_wdata = clamp(PWDATA_IN, slope_pkg::TIM_MIN, slope_pkg::TIM_MAX);
      end
      rd_word = 32'h00000000;
      if (grp_hit) begin
         unique case (PADDR_IN[3:2])
            slope_pkg::FLD_THR: rd_word = 32'(b_thr);
            slope_pkg::FLD_T:   rd_word = 32'(b_t);
            default:            rd_word = 32'(b_minimum_trip_delay);
         endcase
      end else if (PADDR_IN == slope_pkg::OFS_CTRL) begin
         rd_word = {29'h00000000, r.grp, r.en};
      end else if (PADDR_IN == slope_pkg::OFS_STATUS) begin
         rd_word = {27'h0000000, r.lv2, r.st, r.trip, r.start};
      end else if (PADDR_IN == slope_pkg::OFS_IRQ_STAT) begin
         rd_word = {30'h00000000, r.irq_st};
      end else if (PADDR_IN == slope_pkg::OFS_IRQ_MASK) begin
         rd_word = {30'h00000000, r.irq_mask};
      end else if (PADDR_IN == slope_pkg::OFS_SUM) begin
         rd_word = 32'(r.sum);
      end else if (PADDR_IN == slope_pkg::OFS_ELAPSED) begin
         rd_word = 32'(r.el);
      end
   end

   // ----------------------------------------------------------------
   // Stage arithmetic
   // ----------------------------------------------------------------
   logic [slope_pkg::FRQ_W-1:0] slope;
   logic                        above;
   logic [slope_pkg::CNT_W-1:0] t_ticks;
   logic [slope_pkg::CNT_W-1:0] minimum_trip_delay_eff;
   logic [slope_pkg::CNT_W-1:0] el_new;
   logic [slope_pkg::SUM_W-1:0] sum_new;
   logic                        expired;
   logic                        trip_ok;

   always_comb begin
      slope   = (FREQ_IN > r.prev) ? (FREQ_IN - r.prev) : (r.prev - FREQ_IN);
      // One tick of mHz equals one unit of 0.1 Hz/s at a 10 ms tick
      above   = slope > slope_pkg::FRQ_W'(thr);
      t_ticks = to_ticks(t_set);
      minimum_trip_delay_eff = to_ticks(minimum_trip_delay_set);
      if ((thr < slope_pkg::LOW_THR) &&
          (minimum_trip_delay_eff < slope_pkg::CNT_W'(slope_pkg::LOW_MIN_TICKS))) begin
         minimum_trip_delay_eff = slope_pkg::CNT_W'(slope_pkg::LOW_MIN_TICKS);
      end
      el_new  = r.el + 12'h001;
      sum_new = r.sum + slope_pkg::SUM_W'(slope);
      expired = r.el >= t_ticks;
      // trip when sum reaches thr times t
      trip_ok = (sum_new > mul_thr(el_new, thr)) &&
                (sum_new >= mul_thr(t_ticks, thr)) &&
                (el_new >= minimum_trip_delay_eff) && (el_new <= t_ticks);
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic [1:0] ev;
   logic [1:0] clr;

   always_comb begin
      n = r;
      ev  = 2'h0;
      clr = 2'h0;
      n.lv1 = LV_BLOCK_IN;
      n.lv2 = r.lv1;
      n.pready = acc_first;
      if (acc_first) begin
         n.pslverr = ~mapped;
         n.prdata  = PWRITE_IN ? 32'h00000000 : rd_word;
      end else begin
         n.pslverr = 1'b0;
      end
      if (wr_done) begin
         if (PADDR_IN == slope_pkg::OFS_CTRL) begin
            n.en  = PWDATA_IN[slope_pkg::CTRL_EN_BIT];
            n.grp = PWDATA_IN[slope_pkg::CTRL_GRP_LSB +: 2];
         end
         if (PADDR_IN == slope_pkg::OFS_IRQ_STAT) begin
            clr = PWDATA_IN[1:0];
         end
         if (PADDR_IN == slope_pkg::OFS_IRQ_MASK) begin
            n.irq_mask = PWDATA_IN[1:0];
         end
      end
      if (tick) begin
         n.prev      = FREQ_IN;
         n.have_prev = 1'b1;
         if (!r.en || r.lv2) begin
            n.st = slope_pkg::ST_IDLE;
         end else if (r.have_prev) begin
            unique case (r.st)
               slope_pkg::ST_IDLE: begin
                  if (above) begin
                     n.pick = 12'h001;
                     n.st   = slope_pkg::ST_PICKUP;
                  end
               end
               slope_pkg::ST_PICKUP: begin
                  if (!above) begin
                     n.st = slope_pkg::ST_IDLE;
                  end else if (r.pick + 12'h001 >=
                               slope_pkg::CNT_W'(slope_pkg::PICKUP_TICKS)) begin
                     n.st   = slope_pkg::ST_RUN;
                     n.el   = '0;
                     n.sum  = '0;
                     n.stab = '0;
                  end else begin
                     n.pick = r.pick + 12'h001;
                  end
               end
               slope_pkg::ST_RUN: begin
                  if (!(r.trip || expired)) begin
                     n.el  = el_new;
                     n.sum = sum_new;
                     if (el_new >= slope_pkg::CNT_W'(slope_pkg::START_TICKS)) begin
                        n.start = 1'b1;
                     end
                     if (trip_ok) begin
                        n.trip = 1'b1;
                     end
                  end
                  n.stab = above ? '0 : r.stab + 12'h001;
                  if ((r.trip || expired) && !above &&
                      (r.stab + 12'h001 >= slope_pkg::CNT_W'(slope_pkg::STABLE_TICKS))) begin
                     n.st = slope_pkg::ST_IDLE;
                  end
               end
               default: n.st = slope_pkg::ST_IDLE;
            endcase
         end
         if (n.st == slope_pkg::ST_IDLE) begin
            n.start = 1'b0;
            n.trip  = 1'b0;
            n.sum   = '0;
            n.el    = '0;
            n.stab  = '0;
            if (r.st != slope_pkg::ST_IDLE) begin
               n.pick = '0;
            end
         end
      end
      ev[slope_pkg::IRQ_START] = n.start & ~r.start;
      ev[slope_pkg::IRQ_TRIP]  = n.trip & ~r.trip;
      // New event wins over a same-cycle clear
      n.irq_st = (r.irq_st & ~clr) | ev;
      n.irq    = |(n.irq_st & n.irq_mask);
   end

   always_ff @(posedge CORE_CLK_IN or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign PRDATA_OUT  = r.prdata;
   assign PREADY_OUT  = r.pready;
   assign PSLVERR_OUT = r.pslverr;
   assign START_OUT   = r.start;
   assign TRIP_OUT    = r.trip;
   assign IRQ_OUT     = r.irq;

endmodule

// *** tb/slope_stage_properties.sv ***
/*
 Port assertions for the slope stage.
 Assumes a bind onto slope_stage and a single clock domain.
*/
`timescale 1ns/1ns
module slope_stage_checker #(
   parameter int TICK_CYCLES = slope_pkg::TICK_CYCLES
) (
   input wire logic                        CORE_CLK_IN,
   input wire logic                        RSTN_IN,
   input wire logic                        PSEL_IN,
   input wire logic                        PENABLE_IN,
   input wire logic                        PWRITE_IN,
   input wire logic [7:0]                  PADDR_IN,
   input wire logic [31:0]                 PWDATA_IN,
   input wire logic [31:0]                 PRDATA_OUT,
   input wire logic                        PREADY_OUT,
   input wire logic                        PSLVERR_OUT,
   input wire logic [slope_pkg::FRQ_W-1:0] FREQ_IN,
   input wire logic                        LV_BLOCK_IN,
   input wire logic                        START_OUT,
   input wire logic                        TRIP_OUT,
   input wire logic                        IRQ_OUT
);
   // -----------------------------
   // Bus and output properties
   // -----------------------------
   default clocking dc @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   sequence access_s; PSEL_IN && PENABLE_IN && !PREADY_OUT; endsequence
   sequence answer_s; PREADY_OUT ##1 !PREADY_OUT; endsequence
   ready_after_access_a:
      assert property (access_s |=> answer_s) else $error("ready not one cycle after access");
   ready_cause_a:
      assert property (PREADY_OUT |-> $past(PSEL_IN && PENABLE_IN)) else $error("stray ready");
   err_with_ready_a:
      assert property (PSLVERR_OUT |-> PREADY_OUT) else $error("error without ready");
   err_read_zero_a:
      assert property (PSLVERR_OUT && !PWRITE_IN |-> PRDATA_OUT == 32'h0) else $error("err data");
   trip_needs_start_a:
      assert property (TRIP_OUT |-> START_OUT) else $error("trip without start");
   start_before_trip_a:
      assert property ($rose(START_OUT) |-> !TRIP_OUT) else $error("start rose with trip");
   trip_release_a:
      assert property ($fell(TRIP_OUT) |-> !START_OUT) else $error("trip fell alone");
   trip_steady_a:
      assert property ($rose(TRIP_OUT) |-> TRIP_OUT [*8]) else $error("trip glitch");
   start_steady_a:
      assert property ($rose(START_OUT) |-> START_OUT [*8]) else $error("start glitch");
endmodule

// *** tb/tb.sv ***
/*
 Self-checking bench of the slope stage over APB.
 Assumes a short processing tick set through TICK_CYCLES.
*/
`timescale 1ns/1ns
module tb;
   localparam int TK = 20;
   logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, lv = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd_v;
   logic        pready, perr, start, trip, irq, err_v;
   logic [15:0] freq = 16'h7530, step = 16'h0000;
   int          fail_count = 0, n_tests = 0, cyc = 0, ph = 0, n;
   always #25 clk = ~clk;
   slope_stage #(.TICK_CYCLES(TK)) i_slope_stage (.CORE_CLK_IN(clk), .RSTN_IN(rstn),
      .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(perr), .FREQ_IN(freq),
      .LV_BLOCK_IN(lv), .START_OUT(start), .TRIP_OUT(trip), .IRQ_OUT(irq));
   // -----------------------------
   // Stimulus helpers
   // -----------------------------
   // Ramp steps once per tick period so every tick sees the same slope
   always @(posedge clk) begin
      cyc <= cyc + 1;
      ph <= (ph == TK - 1) ? 0 : ph + 1;
      if (ph == 0) freq <= freq + step;
      if (cyc == 40000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("mismatches %0d of %0d comparisons", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd_v = prdata;
      err_v = perr;
      psel <= 1'b0; pen <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd_v, e);
   endtask
   task automatic wait_lvl(input bit tr, input logic lvl, input int lim);
      n = 0;
      while (((tr ? trip : start) !== lvl) && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask
   // Expected trip tick e counted from the start moment, 0 means no trip
   task automatic run(input logic [1:0] g, input logic [31:0] thr, t, tm, input logic [15:0] s,
                      input bit hold, input int e);
      apb(1'b1, 8'h40 + {2'h0, g, 4'h0}, thr);
      apb(1'b1, 8'h44 + {2'h0, g, 4'h0}, t);
      apb(1'b1, 8'h48 + {2'h0, g, 4'h0}, tm);
      apb(1'b1, slope_pkg::OFS_CTRL, {29'h0, g, 1'b1});
      step <= s;
      wait_lvl(1'b0, 1'b1, 40 * TK);
      chk({31'h0, start && n >= 13 * TK && n <= 16 * TK}, 32'h1);
      if (hold) begin
         step <= 16'h0000;
         repeat (10 * TK) @(posedge clk);
         chk({31'h0, start}, 32'h1);
      end
      wait_lvl(1'b1, 1'b1, 300 * TK);
      chk(n, (e == 0) ? 300 * TK : (e - 6) * TK);
      step <= 16'h0000;
      wait_lvl(1'b0, 1'b0, 20 * TK);
      chk({30'h0, trip, start}, 32'h0);
      rd(slope_pkg::OFS_SUM, 32'h0);
      rd(slope_pkg::OFS_ELAPSED, 32'h0);
      apb(1'b1, slope_pkg::OFS_CTRL, 32'h0);
   endtask
   // -----------------------------
   // Main sequence
   // -----------------------------
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      for (int g = 0; g < 4; g++) begin
         rd(8'h40 + 8'(g * 16), 32'h5);
         rd(8'h44 + 8'(g * 16), 32'h1E);
         rd(8'h48 + 8'(g * 16), 32'h1E);
      end
      rd(slope_pkg::OFS_CTRL, 32'h0);
      rd(slope_pkg::OFS_IRQ_MASK, 32'h0);
      apb(1'b0, 8'hFC, 32'h0);
      chk({31'h0, err_v}, 32'h1);
      apb(1'b1, 8'h70, 32'h1);
      rd(8'h70, 32'h2);
      apb(1'b1, 8'h70, 32'h65);
      rd(8'h70, 32'h64);
      apb(1'b1, 8'h74, 32'h6);
      rd(8'h74, 32'h7);
      apb(1'b1, 8'h74, 32'h1F5);
      rd(8'h74, 32'h1F4);
      run(2'h1, 32'h5, 32'h14, 32'h14, 16'd10, 1'b0, 40);
      chk({31'h0, irq}, 32'h0);
      rd(slope_pkg::OFS_IRQ_STAT, 32'h3);
      apb(1'b1, slope_pkg::OFS_IRQ_MASK, 32'h3);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, slope_pkg::OFS_IRQ_STAT, 32'h3);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      run(2'h2, 32'hA, 32'h1E, 32'h7, 16'd40, 1'b0, 15);
      run(2'h3, 32'hA, 32'h1E, 32'h7, 16'd80, 1'b0, 14);
      run(2'h0, 32'h5, 32'h1E, 32'h7, 16'd80, 1'b0, 30);
      run(2'h2, 32'hA, 32'h14, 32'h14, 16'd40, 1'b1, 0);
      apb(1'b1, slope_pkg::OFS_CTRL, 32'h5);
      step <= 16'd40;
      wait_lvl(1'b0, 1'b1, 40 * TK);
      chk({31'h0, start}, 32'h1);
      lv <= 1'b1;
      repeat (3 * TK) @(posedge clk);
      chk({31'h0, start}, 32'h0);
      rd(slope_pkg::OFS_STATUS, 32'h10);
      wrap_up();
   end
endmodule
bind slope_stage slope_stage_checker #(.TICK_CYCLES(TICK_CYCLES)) i_slope_stage_checker (
   .CORE_CLK_IN(CORE_CLK_IN), .RSTN_IN(RSTN_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
   .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
   .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .FREQ_IN(FREQ_IN),
   .LV_BLOCK_IN(LV_BLOCK_IN), .START_OUT(START_OUT), .TRIP_OUT(TRIP_OUT), .IRQ_OUT(IRQ_OUT));
